// *** hw/cam_conn_pkg.sv ***
/*
  Package for the connection-memory CAM block: register offsets, field layout,
  command codes, state-counter widths and packed carrier types.
  Assumes an APB master on pclk; no other surroundings.
*/
package cam_conn_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] cmd_mode_off = 8'h00;
  localparam logic [7:0] loc_ptr_off = 8'h04;
  localparam logic [7:0] indirect_off = 8'h08;
  localparam logic [7:0] fault_off = 8'h0c;
  localparam logic [7:0] state_off = 8'h10;
  localparam logic [7:0] hold_base_off = 8'h14;
  // ------------------------------------------------------------
  // Command mode register fields
  // ------------------------------------------------------------
  localparam int cam_sel_lsb = 6;
  localparam int half_sel_bit = 5;
  localparam logic [3:0] cmd_none = 4'h0;
  localparam logic [3:0] cmd_make = 4'h1;
  localparam logic [3:0] cmd_break = 4'h2;
  localparam logic [3:0] cmd_clear_loc = 4'h3;
  localparam logic [3:0] cmd_read_loc = 4'h4;
  localparam logic [3:0] cmd_find = 4'h5;
  localparam logic [3:0] cmd_reset_cam = 4'h6;
  localparam logic [3:0] cmd_reset_hold = 4'h7;
  localparam logic [3:0] cmd_reset_all = 4'h8;
  localparam logic [1:0] cam_even = 2'h0;
  localparam logic [1:0] cam_odd = 2'h1;
  localparam logic [1:0] cam_local = 2'h3;
  // ------------------------------------------------------------
  // Fault register bits and reset values
  // ------------------------------------------------------------
  localparam int overflow_bit = 0;
  localparam int underflow_bit = 1;
  localparam logic [7:0] cmd_mode_rst = 8'h00;
  localparam logic [12:0] state_rst = 13'h0000;
  // ------------------------------------------------------------
  // Sizes and state functions
  // ------------------------------------------------------------
  localparam int cam_depth = 512;
  localparam int ts_bits = 7;
  localparam int st_bits = 4;
  localparam logic [1:0] fn_compare = 2'h0;
  localparam logic [1:0] fn_retrieve = 2'h1;
  localparam logic [1:0] fn_memory = 2'h2;
  localparam logic [1:0] fn_host = 2'h3;

  // Stored comparand plus control, and register-file data
  typedef struct packed {
    logic valid;
    logic dir_write;
    logic [3:0] stream;
    logic [6:0] slot;
  } cam_key_t;

  typedef struct packed {
    logic pattern;
    logic buf_sel;
    logic [8:0] tag;
    logic [6:0] subrate;
  } tag_entry_t;

  // Data-memory request toward the data SRAM
  typedef struct packed {
    logic wr_req;
    logic rd_req;
    logic pattern;
    logic buf_sel;
    logic [8:0] tag;
  } dm_req_t;
endpackage : cam_conn_pkg

// *** hw/cam_conn_ctrl.sv ***
/*
  Three parallel 512-entry connection CAMs with tag register files, state counter
  and host command engine reached over APB.
  Assumes pclk is the state clock and the APB master follows the usual protocol.
*/
`timescale 1ns/1ps
module cam_conn_ctrl #(
  parameter int depth = cam_conn_pkg::cam_depth
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cam_conn_pkg::dm_req_t dm_even,
  output cam_conn_pkg::dm_req_t dm_odd,
  output cam_conn_pkg::dm_req_t dm_local,
  output logic [12:0] state_count,
  output logic cmd_busy
);
  localparam int aw = $clog2(depth);

  // ------------------------------------------------------------
  // State counter
  // ------------------------------------------------------------
  logic [12:0] state_r;
  logic [1:0] fn;
  logic dir_now;
  assign fn = state_r[1:0];
  assign dir_now = state_r[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cam_conn_pkg::state_rst;
    end else begin
      state_r <= state_r + 13'h0001;
    end
  end

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  logic wr_en, rd_en;
  logic [7:0] cmd_mode_r;
  logic [aw-1:0] loc_ptr_r;
  logic [7:0] hold_r [4];
  logic [1:0] fault_r;
  logic [1:0] rd_idx_r;
  logic cmd_pend_r;
  logic [aw-1:0] found_loc_r;
  logic two_r, two_first;
  logic [aw-1:0] ptr_loc, clr_loc;
  logic set_over, set_under, load_hold, clr_hold, find_done;
  cam_conn_pkg::cam_key_t hold_key;
  cam_conn_pkg::tag_entry_t hold_tag;
  cam_conn_pkg::cam_key_t rd_key;
  cam_conn_pkg::tag_entry_t rd_tag;
  logic [31:0] rdata_nxt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  assign hold_key = '{valid: 1'b1, dir_write: hold_r[1][4], stream: hold_r[1][3:0],
                      slot: hold_r[0][6:0]};
  assign hold_tag = '{pattern: hold_r[1][5], buf_sel: hold_r[1][6],
                      tag: {hold_r[3][0], hold_r[2]}, subrate: hold_r[3][7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_mode_r <= cam_conn_pkg::cmd_mode_rst;
      loc_ptr_r <= '0;
      cmd_pend_r <= 1'b0;
    end else begin
      if (wr_en && paddr == cam_conn_pkg::cmd_mode_off) begin
        cmd_mode_r <= pwdata[7:0];
        cmd_pend_r <= pwdata[3:0] != cam_conn_pkg::cmd_none;
      end else if (fn == cam_conn_pkg::fn_host && cmd_pend_r) begin
        cmd_pend_r <= two_first;
      end
      if (wr_en && paddr == cam_conn_pkg::loc_ptr_off) begin
        loc_ptr_r <= aw'(pwdata[aw-2:0]);
      end
    end
  end

  // Holding registers and indirect read pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) hold_r[i] <= 8'h00;
      rd_idx_r <= 2'h0;
    end else begin
      if (clr_hold) begin
        for (int i = 0; i < 4; i++) hold_r[i] <= 8'h00;
        rd_idx_r <= 2'h0;
      end else if (load_hold) begin
        hold_r[0] <= {rd_key.valid, rd_key.slot};
        hold_r[1] <= {1'b0, rd_tag.buf_sel, rd_tag.pattern, rd_key.dir_write, rd_key.stream};
        hold_r[2] <= rd_tag.tag[7:0];
        hold_r[3] <= {rd_tag.subrate, rd_tag.tag[8]};
        rd_idx_r <= 2'h0;
      end else if (find_done) begin
        rd_idx_r <= 2'h0;
      end else if (wr_en && paddr[7:4] == cam_conn_pkg::hold_base_off[7:4]
                   && paddr[3:2] != 2'h0) begin
        hold_r[paddr[3:2] - 2'h1] <= pwdata[7:0];
      end else if (wr_en && paddr == cam_conn_pkg::hold_base_off) begin
        hold_r[3] <= pwdata[7:0];
      end else if (wr_en && paddr == cam_conn_pkg::indirect_off) begin
        hold_r[rd_idx_r] <= pwdata[7:0];
        rd_idx_r <= rd_idx_r + 2'h1;
      end else if (rd_en && paddr == cam_conn_pkg::indirect_off) begin
        rd_idx_r <= rd_idx_r + 2'h1;
      end
    end
  end

  // Fault flags: hardware set wins over software write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 2'h0;
    end else begin
      fault_r[cam_conn_pkg::overflow_bit] <= set_over ||
        (fault_r[cam_conn_pkg::overflow_bit] &&
         !(wr_en && paddr == cam_conn_pkg::fault_off && pwdata[cam_conn_pkg::overflow_bit]));
      fault_r[cam_conn_pkg::underflow_bit] <= set_under ||
        (fault_r[cam_conn_pkg::underflow_bit] &&
         !(wr_en && paddr == cam_conn_pkg::fault_off && pwdata[cam_conn_pkg::underflow_bit]));
    end
  end

  // ------------------------------------------------------------
  // CAM arrays, comparison and priority
  // ------------------------------------------------------------
  cam_conn_pkg::cam_key_t key_mem [3][depth];
  cam_conn_pkg::tag_entry_t tag_mem [3][depth];
  logic [aw-1:0] hit_loc [3];
  logic hit_any [3];
  logic [aw-1:0] free_loc [3];
  logic free_any [3];
  logic [aw-1:0] cmd_loc [3];
  logic cmd_hit [3];
  logic [1:0] sel_cam;
  logic [1:0] sel_idx;
  logic [aw-1:0] tgt_loc_r;
  logic do_write, do_clear, do_clear_all;
  logic [2:0] clear_cams;
  logic [3:0] cmd;
  cam_conn_pkg::dm_req_t dm_r [3];
  logic [aw-1:0] ret_loc_r [3];
  logic ret_hit_r [3];
  logic ret_dir_r;

  assign cmd = cmd_mode_r[3:0];
  assign sel_cam = cmd_mode_r[cam_conn_pkg::cam_sel_lsb +: 2];
  assign sel_idx = (sel_cam == cam_conn_pkg::cam_local) ? 2'h2 :
                   (sel_cam == cam_conn_pkg::cam_odd) ? 2'h1 : 2'h0;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_cam
      always_comb begin
        hit_any[g] = 1'b0;
        hit_loc[g] = '0;
        free_any[g] = 1'b0;
        free_loc[g] = '0;
        cmd_hit[g] = 1'b0;
        cmd_loc[g] = '0;
        for (int i = depth - 1; i >= 0; i--) begin
          if (key_mem[g][i].valid && key_mem[g][i].dir_write == dir_now &&
              key_mem[g][i].slot == state_r[12:6] && key_mem[g][i].stream == state_r[5:2]) begin
            hit_any[g] = 1'b1;
            hit_loc[g] = aw'(i);
          end
          if (!key_mem[g][i].valid) begin
            free_any[g] = 1'b1;
            free_loc[g] = aw'(i);
          end
          if (key_mem[g][i] == hold_key) begin
            cmd_hit[g] = 1'b1;
            cmd_loc[g] = aw'(i);
          end
        end
      end

      // Read compare then write compare, each retrieved one state later
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ret_hit_r[g] <= 1'b0;
          ret_loc_r[g] <= '0;
          dm_r[g] <= '0;
        end else begin
          if (!fn[1]) begin
            ret_hit_r[g] <= hit_any[g];
            ret_loc_r[g] <= hit_loc[g];
          end
          if (fn == cam_conn_pkg::fn_retrieve || fn == cam_conn_pkg::fn_memory) begin
            dm_r[g].wr_req <= ret_hit_r[g] && ret_dir_r;
            dm_r[g].rd_req <= ret_hit_r[g] && !ret_dir_r;
            dm_r[g].pattern <= tag_mem[g][ret_loc_r[g]].pattern;
            dm_r[g].buf_sel <= tag_mem[g][ret_loc_r[g]].buf_sel;
            dm_r[g].tag <= tag_mem[g][ret_loc_r[g]].tag;
          end else if (fn == cam_conn_pkg::fn_host) begin
            dm_r[g].wr_req <= 1'b0;
            dm_r[g].rd_req <= 1'b0;
          end
        end
      end

      // Entry storage; validity cleared by reset and commands
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int i = 0; i < depth; i++) key_mem[g][i].valid <= 1'b0;
        end else if (clear_cams[g]) begin
          for (int i = 0; i < depth; i++) key_mem[g][i].valid <= 1'b0;
        end else if (do_write && sel_idx == 2'(g)) begin
          key_mem[g][tgt_loc_r] <= hold_key;
        end else if (do_clear && sel_idx == 2'(g)) begin
          key_mem[g][clr_loc].valid <= 1'b0;
        end
      end

      always_ff @(posedge pclk) begin
        if (do_write && sel_idx == 2'(g)) begin
          tag_mem[g][tgt_loc_r] <= hold_tag;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_dir_r <= 1'b0;
    end else if (!fn[1]) begin
      ret_dir_r <= dir_now;
    end
  end

  // ------------------------------------------------------------
  // Command engine, host slot only
  // ------------------------------------------------------------
  logic host_slot;
  assign host_slot = (fn == cam_conn_pkg::fn_host) && cmd_pend_r;
  assign two_first = host_slot && !two_r &&
    ((cmd == cam_conn_pkg::cmd_make && free_any[sel_idx]) ||
     (cmd == cam_conn_pkg::cmd_break && cmd_hit[sel_idx]));
  assign set_over = host_slot && !two_r && cmd == cam_conn_pkg::cmd_make &&
                    !free_any[sel_idx];
  assign set_under = host_slot && !two_r && !cmd_hit[sel_idx] &&
    (cmd == cam_conn_pkg::cmd_break || cmd == cam_conn_pkg::cmd_find);
  assign do_write = host_slot && two_r && cmd == cam_conn_pkg::cmd_make;
  assign do_clear = (host_slot && two_r && cmd == cam_conn_pkg::cmd_break) ||
                    (host_slot && cmd == cam_conn_pkg::cmd_clear_loc);
  assign do_clear_all = host_slot && cmd == cam_conn_pkg::cmd_reset_all;
  assign clear_cams = do_clear_all ? 3'h7 :
    (host_slot && cmd == cam_conn_pkg::cmd_reset_cam) ? (3'h1 << sel_idx) : 3'h0;
  assign clr_hold = host_slot && (cmd == cam_conn_pkg::cmd_reset_hold || do_clear_all);
  assign load_hold = host_slot && cmd == cam_conn_pkg::cmd_read_loc;
  assign find_done = host_slot && cmd == cam_conn_pkg::cmd_find;
  assign ptr_loc = {~cmd_mode_r[cam_conn_pkg::half_sel_bit], loc_ptr_r[aw-2:0]};
  assign clr_loc = two_r ? tgt_loc_r : ptr_loc;
  assign rd_key = key_mem[sel_idx][ptr_loc];
  assign rd_tag = tag_mem[sel_idx][ptr_loc];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_r <= 1'b0;
      tgt_loc_r <= '0;
      found_loc_r <= '0;
    end else begin
      if (two_first) begin
        two_r <= 1'b1;
        tgt_loc_r <= (cmd == cam_conn_pkg::cmd_make) ? free_loc[sel_idx] : cmd_loc[sel_idx];
      end else if (host_slot) begin
        two_r <= 1'b0;
      end
      if (find_done && cmd_hit[sel_idx]) begin
        found_loc_r <= cmd_loc[sel_idx];
      end
    end
  end

  // ------------------------------------------------------------
  // APB read data and outputs
  // ------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      cam_conn_pkg::cmd_mode_off: rdata_nxt = {24'h000000, cmd_mode_r};
      cam_conn_pkg::loc_ptr_off: rdata_nxt = 32'(loc_ptr_r);
      cam_conn_pkg::fault_off: rdata_nxt = {30'h0, fault_r};
      cam_conn_pkg::state_off: rdata_nxt = {19'h0, state_r};
      cam_conn_pkg::indirect_off: begin
        if (cmd == cam_conn_pkg::cmd_find) begin
          rdata_nxt = rd_idx_r[0] ? 32'(found_loc_r[aw-1]) : 32'(found_loc_r[aw-2:0]);
        end else begin
          rdata_nxt = {24'h0, hold_r[rd_idx_r]};
        end
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dm_even <= '0;
      dm_odd <= '0;
      dm_local <= '0;
      state_count <= 13'h0000;
      cmd_busy <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= rdata_nxt;
      dm_even <= dm_r[0];
      dm_odd <= dm_r[1];
      dm_local <= dm_r[2];
      state_count <= state_r;
      cmd_busy <= cmd_pend_r;
    end
  end
endmodule : cam_conn_ctrl

// *** verif/cam_conn_monitor.sv ***
/*
  Checker for the connection CAM block, bound to its top module.
  Assumes only the top module's ports; one clock pclk, reset presetn.
*/
`timescale 1ns/1ps
module cam_conn_monitor #(
  parameter int depth = cam_conn_pkg::cam_depth
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cam_conn_pkg::dm_req_t dm_even,
  input wire cam_conn_pkg::dm_req_t dm_odd,
  input wire cam_conn_pkg::dm_req_t dm_local,
  input wire logic [12:0] state_count,
  input wire logic cmd_busy
);
  // ------------------------------------------------------------
  // Helpers and sequences
  // ------------------------------------------------------------
  logic run_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (state_count != 13'h0) begin
      run_r <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence cmd_taken;
    psel && penable && pready && pwrite && paddr == cam_conn_pkg::cmd_mode_off
      && pwdata[3:0] != 4'h0;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_no_slverr: assert property (!pslverr)
    else $error("pslverr raised");
  chk_ready_answer: assert property (apb_setup |=> pready)
    else $error("pready late after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  chk_count_step: assert property (run_r |=> state_count == $past(state_count) + 13'h1)
    else $error("state counter skipped");
  chk_dm_single: assert property (!(dm_even.wr_req && dm_even.rd_req)
    && !(dm_odd.wr_req && dm_odd.rd_req) && !(dm_local.wr_req && dm_local.rd_req))
    else $error("read and write request together");
  chk_busy_start: assert property (cmd_taken |-> ##[1:2] cmd_busy)
    else $error("command not pending");
  chk_busy_bound: assert property ($rose(cmd_busy) |-> ##[1:8] !cmd_busy)
    else $error("command took too long");
  chk_unmapped_zero: assert property (psel && penable && pready && !pwrite
    && paddr >= 8'h20 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : cam_conn_monitor

bind cam_conn_ctrl cam_conn_monitor #(.depth(depth)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dm_even(dm_even), .dm_odd(dm_odd),
  .dm_local(dm_local), .state_count(state_count), .cmd_busy(cmd_busy));

// *** verif/cam_host_model.sv ***
/*
  Host processor model: APB master with write and read tasks.
  Assumes pclk and a slave that answers with pready.
*/
`timescale 1ns/1ps
module cam_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ------------------------------------------------------------
  // Bus cycle: setup, access held until pready
  // ------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
endmodule : cam_host_model

// *** verif/test_cam_conn_ctrl.sv ***
/*
  Self-checking bench for the connection CAM block, depth shortened to 4.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module test_cam_conn_ctrl;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cam_conn_pkg::dm_req_t dm_even;
  cam_conn_pkg::dm_req_t dm_odd;
  cam_conn_pkg::dm_req_t dm_local;
  logic [12:0] state_count;
  logic cmd_busy;
  logic [31:0] q;
  int fail_count = 0;
  int checked = 0;

  cam_conn_ctrl #(.depth(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dm_even(dm_even), .dm_odd(dm_odd),
    .dm_local(dm_local), .state_count(state_count), .cmd_busy(cmd_busy));
  cam_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task cmd(input logic [1:0] cam, input logic half, input logic [3:0] code);
    int n;
    host.wr(cam_conn_pkg::cmd_mode_off, {24'h0, cam, half, 1'b0, code});
    repeat (2) @(posedge pclk);
    n = 0;
    while (cmd_busy !== 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("cmd_busy", {31'h0, cmd_busy}, 32'h0);
  endtask : cmd
  task load(input logic [6:0] slot, input logic [7:0] ctl, input logic [8:0] tag);
    cmd(2'h0, 1'b0, cam_conn_pkg::cmd_reset_hold);
    host.wr(cam_conn_pkg::indirect_off, {25'h0, slot});
    host.wr(cam_conn_pkg::indirect_off, {24'h0, ctl});
    host.wr(cam_conn_pkg::indirect_off, {24'h0, tag[7:0]});
    host.wr(cam_conn_pkg::indirect_off, {31'h0, tag[8]});
  endtask : load
  task fault(input logic [31:0] exp);
    host.rd(cam_conn_pkg::fault_off, q);
    chk("fault", q, exp);
    host.wr(cam_conn_pkg::fault_off, 32'h3);
  endtask : fault
  task find(input logic [1:0] cam, input logic [8:0] loc);
    cmd(cam, 1'b0, cam_conn_pkg::cmd_find);
    host.rd(cam_conn_pkg::indirect_off, q);
    chk("find_lo", q, {24'h0, loc[7:0]});
    host.rd(cam_conn_pkg::indirect_off, q);
    chk("find_hi", q, {31'h0, loc[8]});
  endtask : find
  task wait_dm(input int which, input logic wr, input logic [8:0] tag, input logic [1:0] pb);
    cam_conn_pkg::dm_req_t r;
    int n;
    n = 0;
    r = '0;
    while (!(wr ? r.wr_req : r.rd_req) && n < 8400) begin
      @(posedge pclk);
      r = (which == 0) ? dm_even : (which == 1) ? dm_odd : dm_local;
      n++;
    end
    chk("dm_req", {31'h0, wr ? r.wr_req : r.rd_req}, 32'h1);
    chk("dm_tag", {23'h0, r.tag}, {23'h0, tag});
    chk("dm_ctl", {30'h0, r.pattern, r.buf_sel}, {30'h0, pb});
  endtask : wait_dm
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    logic [7:0] rb [4];
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    host.rd(cam_conn_pkg::cmd_mode_off, q);
    chk("cmd_rst", q, {24'h0, cam_conn_pkg::cmd_mode_rst});
    host.rd(8'h40, q);
    chk("unmapped", q, 32'h0);
    fault(32'h0);
    cmd(2'h0, 1'b0, cam_conn_pkg::cmd_reset_all);
    load(7'h05, 8'h13, 9'h123);
    cmd(cam_conn_pkg::cam_even, 1'b0, cam_conn_pkg::cmd_make);
    load(7'h05, 8'h03, 9'h123);
    cmd(cam_conn_pkg::cam_local, 1'b0, cam_conn_pkg::cmd_make);
    wait_dm(0, 1'b1, 9'h123, 2'h0);
    wait_dm(2, 1'b0, 9'h123, 2'h0);
    host.wr(cam_conn_pkg::loc_ptr_off, 32'h0);
    cmd(cam_conn_pkg::cam_even, 1'b1, cam_conn_pkg::cmd_read_loc);
    rb = '{8'h85, 8'h13, 8'h23, 8'h01};
    for (int i = 0; i < 4; i++) begin
      host.rd(cam_conn_pkg::indirect_off, q);
      chk("read_loc", q, {24'h0, rb[i]});
    end
    load(7'h06, 8'h13, 9'h045);
    cmd(cam_conn_pkg::cam_even, 1'b0, cam_conn_pkg::cmd_make);
    find(cam_conn_pkg::cam_even, 9'h001);
    cmd(cam_conn_pkg::cam_even, 1'b0, cam_conn_pkg::cmd_break);
    fault(32'h0);
    cmd(cam_conn_pkg::cam_even, 1'b0, cam_conn_pkg::cmd_find);
    fault(32'h2);
    fault(32'h0);
    cmd(cam_conn_pkg::cam_even, 1'b1, cam_conn_pkg::cmd_clear_loc);
    cmd(cam_conn_pkg::cam_even, 1'b1, cam_conn_pkg::cmd_read_loc);
    host.rd(cam_conn_pkg::indirect_off, q);
    chk("cleared", q, 32'h05);
    load(7'h07, 8'h03, 9'h00a);
    for (int i = 0; i < 3; i++) begin
      cmd(cam_conn_pkg::cam_local, 1'b0, cam_conn_pkg::cmd_make);
    end
    fault(32'h0);
    cmd(cam_conn_pkg::cam_local, 1'b0, cam_conn_pkg::cmd_make);
    fault(32'h1);
    find(cam_conn_pkg::cam_local, 9'h001);
    cmd(cam_conn_pkg::cam_local, 1'b0, cam_conn_pkg::cmd_reset_cam);
    cmd(cam_conn_pkg::cam_local, 1'b0, cam_conn_pkg::cmd_find);
    fault(32'h2);
    load(7'h09, 8'h71, 9'h011);
    cmd(cam_conn_pkg::cam_odd, 1'b0, cam_conn_pkg::cmd_make);
    wait_dm(1, 1'b1, 9'h011, 2'h3);
    cmd(2'h0, 1'b0, cam_conn_pkg::cmd_reset_hold);
    for (int i = 0; i < 4; i++) begin
      host.rd(cam_conn_pkg::indirect_off, q);
      chk("hold_rst", q, 32'h0);
    end
    wrap_up();
  end
  initial begin
    #(4 * 60000);
    fail_count++;
    wrap_up();
  end
endmodule : test_cam_conn_ctrl
